// ---- src/vrrc_pkg.sv ----
package vrrc_pkg;
  // ***************************************************
  // Sizes
  // ***************************************************
  localparam int AW = 4;
  localparam int DW = 32;
  localparam int NUM_ELEM = 16;
  localparam int IDX_W = 4;
  localparam int ID_W = 3;
  localparam logic [15:0] ELEM_BASE = 16'h0010;
  localparam logic [15:0] ELEM_LAST = 16'h001f;

  // ***************************************************
  // Register word indexes
  // ***************************************************
  localparam logic [AW-1:0] REG_CMD = 4'h0;
  localparam logic [AW-1:0] REG_ARG0 = 4'h1;
  localparam logic [AW-1:0] REG_ARG1 = 4'h2;
  localparam logic [AW-1:0] REG_ARG2 = 4'h3;
  localparam logic [AW-1:0] REG_TAG = 4'h4;
  localparam logic [AW-1:0] REG_MATCH = 4'h5;
  localparam logic [AW-1:0] REG_STATUS = 4'h6;
  localparam logic [AW-1:0] REG_DATA = 4'h7;
  localparam logic [AW-1:0] REG_LEN = 4'h8;
  localparam logic [AW-1:0] REG_FLAGS = 4'h9;
  localparam logic [AW-1:0] REG_UNIT = 4'ha;

  // ***************************************************
  // Field positions
  // ***************************************************
  localparam int OP_LSB = 0;
  localparam int INIT_LSB = 8;
  localparam int LO16_LSB = 0;
  localparam int HI16_LSB = 16;
  localparam int ALLOC_LSB = 0;
  localparam int VOLUME_TAG_REPORT_BIT_BIT = 24;
  localparam int ELEM_BIT = 0;
  localparam int BEHALF_BIT = 1;
  localparam int BENEF_LSB = 2;
  localparam int NRNG_LSB = 6;
  localparam int ACT_LSB = 0;
  localparam int ST_KEY_LSB = 8;
  localparam int ST_BUSY_BIT = 12;
  localparam int ST_ASC_LSB = 16;
  localparam int ST_ASCQ_LSB = 24;
  localparam int DATA_VLD_BIT = 8;
  localparam int UNIT_VLD_BIT = 3;

  // ***************************************************
  // Command codes, status and sense
  // ***************************************************
  localparam logic [7:0] OP_REPORT = 8'hb5;
  localparam logic [7:0] OP_RESERVE = 8'h16;
  localparam logic [7:0] OP_RELEASE = 8'h17;
  localparam logic [7:0] OP_INQUIRY = 8'h12;
  localparam logic [7:0] OP_REQ_SENSE = 8'h03;
  localparam logic [7:0] STAT_GOOD = 8'h00;
  localparam logic [7:0] STAT_CHECK = 8'h02;
  localparam logic [7:0] STAT_CONFLICT = 8'h18;
  localparam logic [3:0] KEY_NONE = 4'h0;
  localparam logic [3:0] KEY_ILLEGAL = 4'h5;
  localparam logic [7:0] ASC_NONE = 8'h00;
  localparam logic [7:0] ASC_SEQ = 8'h2c;
  localparam logic [7:0] ASC_PARAM = 8'h26;
  localparam logic [7:0] ASCQ_ZERO = 8'h00;
  localparam logic [7:0] ASCQ_BAD_ADDR = 8'h02;
  localparam logic [4:0] ACT_TRANSLATE_MAX = 5'h07;

  // ***************************************************
  // Report layout
  // ***************************************************
  localparam logic [23:0] HDR_LEN = 24'h000008;
  localparam logic [4:0] DESC_SH_PLAIN = 5'h03;
  localparam logic [4:0] DESC_SH_TAG = 5'h04;
  localparam logic [1:0] NRNG_MAX = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SCAN = 2'b01,
    ST_SEND = 2'b11,
    ST_FIN = 2'b10
  } vrrc_state_e;
endpackage

// ---- src/vrrc_top.sv ----
// Chosen here: the strobed register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// Contract
// [RULE1] Initiators should hold a unit reservation around tag and report.
// [RULE2] Report requests ignore every reservation, reporting all flagged.
// [RULE3] A reported element stays silent until the next tag request.
// [RULE4] Volume tag bytes appear only when the tag request bit is set.
// [RULE5] After translate, starting address is the lowest eligible address.
// [RULE6] After assert, replace or undefine, report fails with no data.
// [RULE7] Sequence failure gives sense 5, code 2C, qualifier 00.
// [RULE8] No more descriptors than the element count field allows.
// [RULE9] Transfer the smaller of allocation and available bytes.
// [RULE10] Short allocation is no error; only whole descriptors are sent.
// [RULE11] Zero allocation sends no data bytes.
// [RULE12] Report opens with the eight-byte header, then status pages.
// [RULE13] Header first address is the lowest matching element address.
// [RULE14] Header count is all matching descriptors, sent or not.
// [RULE15] Header action code echoes the last completed tag request.
// [RULE16] Header byte count is status bytes without truncation.
// [RULE17] Reserve takes unit or elements, for self or a beneficiary.
// [RULE18] Reservations last until owner release, bus reset or hard reset.
// [RULE19] Element held by another initiator cannot be reserved.
// [RULE20] No element reservation while the unit is reserved.
// [RULE21] Reserve requests with overlapping ranges are rejected.
// [RULE22] Nonexistent element addresses cannot be reserved.
// [RULE23] Element holds do not block tag work; translate clears all flags.
// [RULE24] Report ascends by address and clears each reported flag.
// [RULE25] Unit held: other initiators get conflict except three commands.
module vrrc_top (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [vrrc_pkg::AW-1:0] addr,
  input wire logic [vrrc_pkg::DW-1:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [vrrc_pkg::DW-1:0] rd_data,
  input wire logic bus_reset_pin,
  output logic cmd_done
);
  import vrrc_pkg::*;

  // ***************************************************
  // Decode and software registers
  // ***************************************************
  vrrc_state_e state_r;
  logic [DW-1:0] arg0_r, arg1_r, arg2_r;
  logic [NUM_ELEM-1:0] match_r, flags_r;
  logic go, go_report, go_reserve, tag_wr, pop;
  logic [7:0] op;
  logic [ID_W-1:0] init_id;

  assign op = wr_data[OP_LSB +: 8];
  assign init_id = wr_data[INIT_LSB +: ID_W];
  assign go = wr_en && addr == REG_CMD && state_r == ST_IDLE;
  assign go_report = go && op == OP_REPORT;
  assign go_reserve = go && op == OP_RESERVE;
  assign tag_wr = wr_en && addr == REG_TAG && state_r == ST_IDLE;
  assign pop = rd_en && addr == REG_DATA && state_r == ST_SEND;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      arg0_r <= '0;
      arg1_r <= '0;
      arg2_r <= '0;
      match_r <= '0;
    end else if (wr_en) begin
      if (addr == REG_ARG0) arg0_r <= wr_data;
      if (addr == REG_ARG1) arg1_r <= wr_data;
      if (addr == REG_ARG2) arg2_r <= wr_data;
      if (addr == REG_MATCH) match_r <= wr_data[NUM_ELEM-1:0];
    end
  end

  // Bus device reset arrives from the pins
  logic bdr_s1_r, bdr_s2_r;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      bdr_s1_r <= 1'b0;
      bdr_s2_r <= 1'b0;
    end else begin
      bdr_s1_r <= bus_reset_pin;
      bdr_s2_r <= bdr_s1_r;
    end
  end

  // ***************************************************
  // Tag request outcome
  // ***************************************************
  logic tag_ok_r;
  logic [4:0] act_r;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      tag_ok_r <= 1'b0;
      act_r <= '0;
    end else if (tag_wr) begin
      act_r <= wr_data[ACT_LSB +: 5]; // [RULE15]
      tag_ok_r <= wr_data[ACT_LSB +: 5] <= ACT_TRANSLATE_MAX; // [RULE6]
    end
  end

  // ***************************************************
  // Report scan
  // ***************************************************
  logic [15:0] req_start_r, req_cnt_r, found_r, first_r;
  logic [23:0] req_alloc_r, byte_idx_r;
  logic [4:0] req_sh_r;
  logic [IDX_W:0] scan_r;
  logic [IDX_W-1:0] list_r [NUM_ELEM];
  logic [15:0] scan_addr;
  logic scan_hit;

  assign scan_addr = ELEM_BASE + 16'(scan_r);
  // Reservations are not consulted here at all
  assign scan_hit = scan_r < (IDX_W+1)'(NUM_ELEM) && flags_r[scan_r[IDX_W-1:0]]
    && scan_addr >= req_start_r && found_r < req_cnt_r; // [RULE2] [RULE5] [RULE8]

  always_ff @(posedge core_clk) begin
    if (rst) begin
      req_start_r <= '0;
      req_cnt_r <= '0;
      req_alloc_r <= '0;
      req_sh_r <= DESC_SH_PLAIN;
    end else if (go_report) begin
      req_start_r <= arg0_r[LO16_LSB +: 16];
      req_cnt_r <= arg0_r[HI16_LSB +: 16];
      req_alloc_r <= arg1_r[ALLOC_LSB +: 24];
      req_sh_r <= arg1_r[VOLUME_TAG_REPORT_BIT_BIT] ? DESC_SH_TAG : DESC_SH_PLAIN; // [RULE4]
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst || go_report) begin
      scan_r <= '0;
      found_r <= '0;
      first_r <= '0;
    end else if (state_r == ST_SCAN) begin
      scan_r <= scan_r + 1'b1; // [RULE24]
      if (scan_hit) begin
        found_r <= found_r + 1'b1; // [RULE14]
        if (found_r == '0) first_r <= scan_addr; // [RULE13]
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (state_r == ST_SCAN && scan_hit)
      list_r[found_r[IDX_W-1:0]] <= scan_r[IDX_W-1:0];
  end

  // ***************************************************
  // Lengths
  // ***************************************************
  logic [23:0] avail_c, total_c, fit_c, xfer_c, sent_c, rel_c;
  assign avail_c = 24'(found_r) << req_sh_r; // [RULE16]
  assign total_c = HDR_LEN + avail_c;
  assign fit_c = (req_alloc_r > HDR_LEN) ?
    HDR_LEN + (((req_alloc_r - HDR_LEN) >> req_sh_r) << req_sh_r) : req_alloc_r;
  // Header may be cut short; descriptors never are
  assign xfer_c = (fit_c < total_c) ? fit_c : total_c; // [RULE9] [RULE10]
  assign sent_c = (xfer_c > HDR_LEN) ? (xfer_c - HDR_LEN) >> req_sh_r : '0;
  assign rel_c = byte_idx_r - HDR_LEN;

  // ***************************************************
  // Byte stream
  // ***************************************************
  logic [7:0] byte_c;
  logic [23:0] desc_c, off_c;
  logic [15:0] desc_addr;
  assign desc_c = rel_c >> req_sh_r;
  assign off_c = rel_c & ((24'h000001 << req_sh_r) - 24'h000001);
  assign desc_addr = ELEM_BASE + 16'(list_r[desc_c[IDX_W-1:0]]);

  always_comb begin
    byte_c = 8'h00;
    if (byte_idx_r < HDR_LEN) begin
      unique case (byte_idx_r[2:0]) // [RULE12]
        3'h0: byte_c = first_r[15:8];
        3'h1: byte_c = first_r[7:0];
        3'h2: byte_c = found_r[15:8];
        3'h3: byte_c = found_r[7:0];
        3'h4: byte_c = {3'h0, act_r};
        3'h5: byte_c = avail_c[23:16];
        3'h6: byte_c = avail_c[15:8];
        3'h7: byte_c = avail_c[7:0];
      endcase
    end else if (off_c == 24'h000000) begin
      byte_c = desc_addr[15:8];
    end else if (off_c == 24'h000001) begin
      byte_c = desc_addr[7:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst || go_report) byte_idx_r <= '0;
    else if (pop) byte_idx_r <= byte_idx_r + 24'h000001;
  end

  // ***************************************************
  // Sequencer
  // ***************************************************
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_r <= ST_IDLE;
    end else begin
      unique case (state_r)
        ST_IDLE: if (go_report && tag_ok_r) state_r <= ST_SCAN;
        ST_SCAN: if (scan_r == (IDX_W+1)'(NUM_ELEM))
          state_r <= (xfer_c == '0) ? ST_FIN : ST_SEND; // [RULE11]
        ST_SEND: if (pop && byte_idx_r == xfer_c - 24'h000001)
          state_r <= ST_FIN;
        ST_FIN: state_r <= ST_IDLE;
      endcase
    end
  end

  // Flags: translate reloads all, report clears what was sent
  always_ff @(posedge core_clk) begin
    if (rst) begin
      flags_r <= '0;
    end else if (tag_wr && wr_data[ACT_LSB +: 5] <= ACT_TRANSLATE_MAX) begin
      flags_r <= match_r; // [RULE23]
    end else if (state_r == ST_FIN) begin
      for (int i = 0; i < NUM_ELEM; i++)
        if (24'(i) < sent_c) flags_r[list_r[i]] <= 1'b0; // [RULE3] [RULE24]
    end
  end

  // ***************************************************
  // Reservation checks
  // ***************************************************
  logic [NUM_ELEM-1:0] el_vld_r, in_rng;
  logic [ID_W-1:0] el_own_r [NUM_ELEM];
  logic [ID_W-1:0] el_rsv_r [NUM_ELEM];
  logic unit_vld_r;
  logic [ID_W-1:0] unit_own_r, unit_rsv_r, req_owner;
  logic [16:0] st0, st1, end0, end1;
  logic use0, use1, bad_addr, overlap, el_clash, any_clash, res_ok;
  logic [7:0] res_stat, res_asc, res_ascq;
  logic [3:0] res_key;
  logic [1:0] nrng;

  assign req_owner = arg0_r[BEHALF_BIT] ? arg0_r[BENEF_LSB +: ID_W] : init_id;
  assign nrng = arg0_r[NRNG_LSB +: 2];
  assign use0 = nrng != 2'h0;
  assign use1 = nrng >= NRNG_MAX;
  assign st0 = {1'b0, arg1_r[LO16_LSB +: 16]};
  assign st1 = {1'b0, arg2_r[LO16_LSB +: 16]};
  // Count of zero runs to the last element
  assign end0 = (arg1_r[HI16_LSB +: 16] == '0) ? {1'b0, ELEM_LAST} :
    st0 + {1'b0, arg1_r[HI16_LSB +: 16]} - 17'h00001;
  assign end1 = (arg2_r[HI16_LSB +: 16] == '0) ? {1'b0, ELEM_LAST} :
    st1 + {1'b0, arg2_r[HI16_LSB +: 16]} - 17'h00001;
  assign bad_addr = (use0 && (st0 < {1'b0, ELEM_BASE} ||
    end0 > {1'b0, ELEM_LAST} || st0 > end0)) || (use1 &&
    (st1 < {1'b0, ELEM_BASE} || end1 > {1'b0, ELEM_LAST} || st1 > end1)); // [RULE22]
  assign overlap = use1 && st0 <= end1 && st1 <= end0; // [RULE21]

  always_comb begin
    logic [16:0] a;
    a = '0;
    in_rng = '0;
    el_clash = 1'b0;
    any_clash = 1'b0;
    for (int i = 0; i < NUM_ELEM; i++) begin
      a = {1'b0, ELEM_BASE} + 17'(i);
      in_rng[i] = (use0 && a >= st0 && a <= end0) ||
        (use1 && a >= st1 && a <= end1);
      if (el_vld_r[i] && el_own_r[i] != req_owner) begin
        any_clash = 1'b1;
        if (in_rng[i]) el_clash = 1'b1; // [RULE19]
      end
    end
  end

  always_comb begin
    res_stat = STAT_GOOD;
    res_key = KEY_NONE;
    res_asc = ASC_NONE;
    res_ascq = ASCQ_ZERO;
    if (arg0_r[ELEM_BIT]) begin
      if (unit_vld_r) begin
        res_stat = STAT_CONFLICT; // [RULE20]
      end else if (overlap || bad_addr) begin
        res_stat = STAT_CHECK;
        res_key = KEY_ILLEGAL;
        res_asc = ASC_PARAM;
        res_ascq = overlap ? ASCQ_ZERO : ASCQ_BAD_ADDR;
      end else if (el_clash) begin
        res_stat = STAT_CONFLICT;
      end
    end else if ((unit_vld_r && unit_own_r != req_owner) || any_clash) begin
      res_stat = STAT_CONFLICT;
    end
  end
  assign res_ok = res_stat == STAT_GOOD;

  // ***************************************************
  // Reservation state
  // ***************************************************
  always_ff @(posedge core_clk) begin
    if (rst || bdr_s2_r) begin
      unit_vld_r <= 1'b0; // [RULE18]
      unit_own_r <= '0;
      unit_rsv_r <= '0;
      el_vld_r <= '0;
      for (int i = 0; i < NUM_ELEM; i++) begin
        el_own_r[i] <= '0;
        el_rsv_r[i] <= '0;
      end
    end else if (go_reserve && res_ok) begin
      if (!arg0_r[ELEM_BIT]) begin
        unit_vld_r <= 1'b1; // [RULE17]
        unit_own_r <= req_owner;
        unit_rsv_r <= init_id;
      end else begin
        for (int i = 0; i < NUM_ELEM; i++) begin
          if (in_rng[i]) begin
            el_vld_r[i] <= 1'b1; // [RULE17]
            el_own_r[i] <= req_owner;
            el_rsv_r[i] <= init_id;
          end
        end
      end
    end else if (go && op == OP_RELEASE) begin
      // Only the reserver releases, never the beneficiary
      if (unit_rsv_r == init_id) unit_vld_r <= 1'b0; // [RULE18]
      for (int i = 0; i < NUM_ELEM; i++)
        if (el_rsv_r[i] == init_id) el_vld_r[i] <= 1'b0;
    end
  end

  // ***************************************************
  // Completion status
  // ***************************************************
  logic [7:0] stat_r, asc_r, ascq_r;
  logic [3:0] key_r;
  logic gate_clash, exempt;
  assign exempt = op == OP_INQUIRY || op == OP_REQ_SENSE || op == OP_RELEASE;
  assign gate_clash = unit_vld_r && unit_own_r != init_id;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      stat_r <= STAT_GOOD;
      key_r <= KEY_NONE;
      asc_r <= ASC_NONE;
      ascq_r <= ASCQ_ZERO;
      cmd_done <= 1'b0;
    end else begin
      cmd_done <= 1'b0;
      if (go_report && !tag_ok_r) begin
        stat_r <= STAT_CHECK; // [RULE6]
        key_r <= KEY_ILLEGAL; // [RULE7]
        asc_r <= ASC_SEQ;
        ascq_r <= ASCQ_ZERO;
        cmd_done <= 1'b1;
      end else if (go_reserve) begin
        stat_r <= res_stat;
        key_r <= res_key;
        asc_r <= res_asc;
        ascq_r <= res_ascq;
        cmd_done <= 1'b1;
      end else if ((go && !go_report) || state_r == ST_FIN) begin
        stat_r <= (go && gate_clash && !exempt) ? STAT_CONFLICT
          : STAT_GOOD; // [RULE25]
        key_r <= KEY_NONE;
        asc_r <= ASC_NONE;
        ascq_r <= ASCQ_ZERO;
        cmd_done <= 1'b1;
      end
    end
  end

  // ***************************************************
  // Read port
  // ***************************************************
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rd_data <= '0;
    end else if (rd_en) begin
      unique case (addr)
        REG_ARG0: rd_data <= arg0_r;
        REG_ARG1: rd_data <= arg1_r;
        REG_ARG2: rd_data <= arg2_r;
        REG_TAG: rd_data <= {27'h0, act_r};
        REG_MATCH: rd_data <= {16'h0, match_r};
        REG_STATUS: rd_data <= {ascq_r, asc_r, 3'h0,
          state_r != ST_IDLE, key_r, stat_r};
        REG_DATA: rd_data <= {23'h0, state_r == ST_SEND,
          (state_r == ST_SEND) ? byte_c : 8'h00};
        REG_LEN: rd_data <= {8'h0, xfer_c};
        REG_FLAGS: rd_data <= {16'h0, flags_r};
        REG_UNIT: rd_data <= {28'h0, unit_vld_r, unit_own_r};
        default: rd_data <= '0;
      endcase
    end
  end

  // ***************************************************
  // Checks
  // ***************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_bad_report;
    go_report && !tag_ok_r;
  endsequence
  sequence s_check_seq;
    stat_r == STAT_CHECK && key_r == KEY_ILLEGAL && asc_r == ASC_SEQ
      && cmd_done && state_r == ST_IDLE;
  endsequence
  chk_seq_error: assert property (s_bad_report |=> s_check_seq) // [RULE7]
    else $error("sequence error not reported");
  chk_no_data_fail: assert property (s_bad_report |=> state_r == ST_IDLE [*2]) // [RULE6]
    else $error("failed report entered data phase");
  chk_zero_alloc: assert property (state_r == ST_SEND |-> req_alloc_r != '0) // [RULE11]
    else $error("data phase with zero allocation");
  chk_xfer_bound: assert property (state_r == ST_SEND |-> // [RULE9]
    xfer_c <= req_alloc_r && xfer_c <= total_c)
    else $error("transfer exceeds limit");
  chk_whole_desc: assert property (state_r == ST_SEND && xfer_c > HDR_LEN |-> // [RULE10]
    ((xfer_c - HDR_LEN) & ((24'h000001 << req_sh_r) - 24'h000001)) == '0)
    else $error("partial descriptor");
  chk_count_cap: assert property (state_r != ST_IDLE |-> found_r <= req_cnt_r) // [RULE8]
    else $error("too many descriptors");
  chk_flag_clear: assert property (state_r == ST_FIN && sent_c != '0 && !tag_wr // [RULE24]
    |=> !flags_r[$past(list_r[0])])
    else $error("reported flag not cleared");
  chk_unit_blocks: assert property (go_reserve && arg0_r[ELEM_BIT] && unit_vld_r // [RULE20]
    |=> stat_r == STAT_CONFLICT && $stable(el_vld_r))
    else $error("element reserved in held unit");
  chk_overlap_rej: assert property (go_reserve && arg0_r[ELEM_BIT] && !unit_vld_r // [RULE21]
    && overlap |=> stat_r == STAT_CHECK && asc_r == ASC_PARAM && $stable(el_vld_r))
    else $error("overlap accepted");
  chk_bdr_clear: assert property (bdr_s2_r |=> !unit_vld_r && el_vld_r == '0) // [RULE18]
    else $error("bus reset left reservation");
endmodule
`default_nettype wire

// ---- tb/vrrc_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ***************************************************
// Initiator side of the command port
// ***************************************************
// Strobes change only after a rising edge and hold for one cycle.
// Write data is inverted once released, so stale data never matches.
module vrrc_host_model (
  input wire logic core_clk,
  output logic [vrrc_pkg::AW-1:0] addr,
  output logic [vrrc_pkg::DW-1:0] wr_data,
  output logic wr_en,
  output logic rd_en,
  input wire logic [vrrc_pkg::DW-1:0] rd_data
);
  import vrrc_pkg::*;
  initial begin
    addr = '0;
    wr_data = '0;
    wr_en = 1'b0;
    rd_en = 1'b0;
  end
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge core_clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge core_clk);
    wr_en <= 1'b0;
    wr_data <= ~d;
  endtask
  // Read data stands from the cycle after the strobe until the next read
  task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] d);
    @(posedge core_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge core_clk);
    rd_en <= 1'b0;
    #1;
    d = rd_data;
  endtask
endmodule
`default_nettype wire

// ---- tb/vrrc_top_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module vrrc_top_tb_top;
  import vrrc_pkg::*;
  // ***************************************************
  // Harness
  // ***************************************************
  logic core_clk, rst, bus_reset_pin, cmd_done, wr_en, rd_en;
  logic [AW-1:0] addr;
  logic [DW-1:0] wr_data, rd_data, rv;
  logic [31:0] seed;
  logic [15:0] flags;
  logic [4:0] act;
  logic [7:0] ops [3] = '{OP_INQUIRY, OP_REQ_SENSE, 8'h00};
  logic [23:0] als [3] = '{24'h0, 24'h14, 24'h100};
  int failures = 0;
  int n_checks = 0;
  int n_done = 0;
  vrrc_top i_vrrc_top (.core_clk(core_clk), .rst(rst), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .bus_reset_pin(bus_reset_pin), .cmd_done(cmd_done));
  vrrc_host_model i_vrrc_host_model (.core_clk(core_clk), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data));
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    if (cmd_done === 1'b1) begin
      n_done <= n_done + 1;
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // Short allocation keeps only whole descriptors
  function automatic int exp_len(input int al, input int tot, input int dsz);
    int n;
    n = (al <= 8) ? al : 8 + ((al - 8) / dsz) * dsz;
    return (n < tot) ? n : tot;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic w(input logic [AW-1:0] a, input logic [31:0] d);
    i_vrrc_host_model.wr(a, d);
  endtask
  task automatic r(input logic [AW-1:0] a);
    i_vrrc_host_model.rd(a, rv);
  endtask
  task automatic wait_done(input int rec);
    for (int k = 0; k < 40 && n_done == rec; k++) @(posedge core_clk);
    if (n_done == rec) begin
      failures++;
      conclude();
    end
  endtask
  task automatic cmd(input logic [7:0] op, input logic [2:0] ini);
    int rec;
    rec = n_done;
    w(REG_CMD, {21'h0, ini, op});
    wait_done(rec);
  endtask
  task automatic rsv(input logic [2:0] ini, input logic [31:0] a0,
                     input logic [31:0] a1, input logic [31:0] a2);
    w(REG_ARG0, a0);
    w(REG_ARG1, a1);
    w(REG_ARG2, a2);
    cmd(OP_RESERVE, ini);
  endtask
  task automatic stat(input logic [7:0] st, input logic [3:0] k,
                      input logic [7:0] c, input logic [7:0] q);
    r(REG_STATUS);
    chk(rv, {q, c, 4'h0, k, st});
  endtask
  // Report from initiator 2; the flag model tracks what is still owed
  task automatic report(input logic [15:0] s, input logic [23:0] al,
                        input logic vt);
    int found, dsz, len, i, j, rec;
    logic [15:0] hit [$];
    logic [63:0] h;
    logic [7:0] e;
    hit = {};
    for (i = 0; i < 16; i++) begin
      if (flags[i] && 16 + i >= s) hit.push_back(16'(16 + i));
    end
    found = hit.size();
    dsz = vt ? 16 : 8;
    len = exp_len(al, 8 + found * dsz, dsz);
    h = {(found > 0) ? hit[0] : 16'h0, 16'(found), 3'h0, act,
         24'(found * dsz)};
    w(REG_ARG0, {16'hffff, s});
    w(REG_ARG1, {7'h0, vt, al});
    rec = n_done;
    w(REG_CMD, {21'h0, 3'h2, OP_REPORT});
    repeat (18) @(posedge core_clk);
    r(REG_LEN);
    chk(rv, 32'(len));
    for (i = 0; i < len; i++) begin
      r(REG_DATA);
      j = (i - 8) / dsz;
      if (i < 8) e = h[63 - 8 * i -: 8];
      else if ((i - 8) % dsz == 0) e = hit[j][15:8];
      else if ((i - 8) % dsz == 1) e = hit[j][7:0];
      else e = 8'h00;
      // First address is undefined when nothing matched
      if (i >= 2 || found > 0) begin
        chk(rv, {23'h0, 1'b1, e});
      end
    end
    wait_done(rec);
    for (i = 0; i < (len - 8) / dsz; i++) flags[hit[i] - 16'h10] = 1'b0;
    r(REG_FLAGS);
    chk(rv, {16'h0, flags});
    stat(STAT_GOOD, KEY_NONE, ASC_NONE, ASCQ_ZERO);
    $display("report test done, length %0d", len);
  endtask
  // ***************************************************
  // Scenarios
  // ***************************************************
  initial begin
    rst = 1'b1;
    bus_reset_pin = 1'b0;
    seed = 32'ha2076a12;
    flags = 16'h0;
    act = 5'h0;
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    cmd(OP_REPORT, 3'h2);
    stat(STAT_CHECK, KEY_ILLEGAL, ASC_SEQ, ASCQ_ZERO);
    w(REG_TAG, 32'h8);
    cmd(OP_REPORT, 3'h2);
    stat(STAT_CHECK, KEY_ILLEGAL, ASC_SEQ, ASCQ_ZERO);
    r(REG_LEN);
    chk(rv, 32'h0);
    $display("sequence error test done");
    rsv(3'h1, 32'h0, 32'h0, 32'h0);
    r(REG_UNIT);
    chk(rv, 32'h9);
    for (int i = 0; i < 3; i++) begin
      cmd(ops[i], 3'h3);
      r(REG_STATUS);
      chk(rv[7:0], (i == 2) ? STAT_CONFLICT : STAT_GOOD);
    end
    rsv(3'h1, 32'h41, 32'h0001_0012, 32'h0);
    r(REG_STATUS);
    chk(32'(rv[7:0] == STAT_GOOD), 32'h0);
    bus_reset_pin <= 1'b1;
    repeat (4) @(posedge core_clk);
    bus_reset_pin <= 1'b0;
    r(REG_UNIT);
    chk(rv, 32'h0);
    $display("unit reservation test done");
    rsv(3'h1, 32'h41, 32'h0001_0012, 32'h0);
    stat(STAT_GOOD, KEY_NONE, ASC_NONE, ASCQ_ZERO);
    rsv(3'h4, 32'h41, 32'h0001_0012, 32'h0);
    r(REG_STATUS);
    chk(rv[7:0], STAT_CONFLICT);
    rsv(3'h4, 32'h81, 32'h0003_0014, 32'h0002_0015);
    stat(STAT_CHECK, KEY_ILLEGAL, ASC_PARAM, ASCQ_ZERO);
    rsv(3'h4, 32'h41, 32'h0001_0030, 32'h0);
    stat(STAT_CHECK, KEY_ILLEGAL, ASC_PARAM, ASCQ_BAD_ADDR);
    $display("element reservation test done");
    // Element 0x12 stays held by initiator 1 while initiator 2 reports
    for (int t = 0; t < 3; t++) begin
      seed = lfsr(seed);
      act = {2'h0, seed[18:16]};
      flags = seed[15:0];
      w(REG_MATCH, {16'h0, flags});
      w(REG_TAG, {27'h0, act});
      r(REG_FLAGS);
      chk(rv, {16'h0, flags});
      report(16'h10 + 16'(seed[23:20]), als[t], seed[24]);
      report(16'h10, 24'h100, seed[25]);
    end
    conclude();
  end
endmodule
`default_nettype wire
